// File: include/scrfc_pkg.sv
// constants and types shared by the scr firing controller files
package scrfc_pkg;
	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;
	localparam int unsigned PULSE_MAX_US  = 2000;     // max gate pulse width
	localparam int unsigned ZC_TO_MS      = 40;       // zero-cross watchdog
	localparam int unsigned ADC_WIN_US    = 1000;     // post-edge adc window
	localparam int unsigned NO_MOTION_TIMEOUT_S      = 30;       // no-motion timeout
	localparam int unsigned TICK_MS       = 220;      // tick timer period
	localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_US * CLK_KHZ / 1000;
	localparam int unsigned ZC_TO_CYC     = ZC_TO_MS * CLK_KHZ;
	localparam int unsigned ADC_WIN_CYC   = ADC_WIN_US * CLK_KHZ / 1000;
	localparam int unsigned NO_MOTION_TIMEOUT_CYC    = NO_MOTION_TIMEOUT_S * CLK_HZ;
	localparam int unsigned TICK_CYC      = TICK_MS * CLK_KHZ;

	// ****************************************************************
	// counts, widths and reset values
	// ****************************************************************
	localparam int unsigned CW          = 24;         // timer count width
	localparam int unsigned AW          = 12;         // adc sample width
	localparam logic [3:0]  OC_LIMIT    = 4'h8;       // overcurrent halves
	localparam logic [2:0]  UC_LIMIT    = 3'h4;       // undercurrent halves
	localparam logic [1:0]  ZC_TO_GATED = 2'h2;       // crossings in pwm
	localparam int unsigned ADC_REF_MV  = 3300;
	localparam int unsigned ADC_MIN_MV  = 220;        // software threshold
	localparam logic [AW-1:0] ADC_MIN_DEF =
		AW'(ADC_MIN_MV * 4096 / ADC_REF_MV);

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {SCRFC_ST_OFF, SCRFC_ST_PWM, SCRFC_ST_GATED}
		scrfc_state_t;
	typedef enum logic [1:0] {SCRFC_TM_OFF, SCRFC_TM_PWM, SCRFC_TM_GATED}
		scrfc_tmode_t;
	typedef enum logic [2:0] {SCRFC_F_NONE, SCRFC_F_ZC_TO, SCRFC_F_OVER,
		SCRFC_F_UNDER, SCRFC_F_MOTION} scrfc_fault_t;
endpackage

// File: include/scrfc_tmr_if.sv
// carrier between the firing controller and its gate pulse timer
`timescale 1ns/10ps
interface scrfc_tmr_if;
	import scrfc_pkg::*;
	scrfc_tmode_t  mode;
	logic [CW-1:0] reload;
	logic [CW-1:0] pwm_width;
	logic          clear;
	logic          force_high;
	logic          gate;
	logic          reload_evt;
	logic [CW-1:0] count;
	logic          out_n;
	modport ctrl (output mode, reload, pwm_width, clear, force_high, gate,
		input reload_evt, count, out_n);
	modport tmr (input mode, reload, pwm_width, clear, force_high, gate,
		output reload_evt, count, out_n);
endinterface

// File: design/scrfc_timer.sv
// gate pulse timer with pwm and gated modes
`timescale 1ns/10ps
module scrfc_timer (
	// clock and reset
	input  wire logic   clk,
	input  wire logic   resetn,
	// controller side
	scrfc_tmr_if.tmr    tif
);
	import scrfc_pkg::*;

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          out_n;
	} scrfc_tmr_st_t;

	scrfc_tmr_st_t q, d;
	logic [CW-1:0] lim;
	logic          wrap;

	// zero reload behaves as one so the counter cannot run away
	assign lim  = (tif.reload == '0) ? '0 : tif.reload - CW'(1);
	assign wrap = (q.cnt >= lim);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		tif.reload_evt = 1'b0;
		unique case (tif.mode)
			SCRFC_TM_OFF: begin
				d.cnt   = '0;
				d.out_n = 1'b1;
			end
			SCRFC_TM_PWM: begin
				d.cnt   = wrap ? '0 : q.cnt + CW'(1);
				d.out_n = ~(d.cnt < tif.pwm_width); // low pulse per period
				tif.reload_evt = wrap;
			end
			SCRFC_TM_GATED: begin
				if (tif.clear) begin
					d.cnt   = '0;
					d.out_n = 1'b1;
				end else if (tif.gate) begin    // counts only while zc low
					if (wrap) begin
						d.cnt   = '0;
						d.out_n = ~q.out_n;
						tif.reload_evt = 1'b1;
					end else begin
						d.cnt = q.cnt + CW'(1);
					end
				end
			end
			default: begin
				d.cnt   = '0;
				d.out_n = 1'b1;
			end
		endcase
		if (tif.force_high)
			d.out_n = 1'b1;
	end

	assign tif.count = q.cnt;
	assign tif.out_n = q.out_n;

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q.cnt   <= '0;
			q.out_n <= 1'b1;
		end else begin
			q <= d;
		end
	end
endmodule

// File: design/scrfc_ctrl.sv
// scr firing controller for the conducting state
// Notes on behaviour
// - on entry the pulse timer runs pwm with acquired period, low pulses
// - in on state voltage edge irq off, current falling edge irq on
// - each current edge stamps watchdog count, then flips edge polarity
// - pwm until two full crossings seen, then edges off, gated mode
// - gated timer counts only while zc low; events at rise and reload
// - first gated reload after fall toggles the gate output low, later reloads force it high
// - reload becomes half last crossing at rise and at mode switch
// - first reload after fall sets reload to max pulse width, 2 ms
// - second reload ends pulse; duration is reload sum plus residual
// - no falling edge means no gate pulse for that half-cycle
// - no current edges for 40 ms gives zc timeout and off
// - overcurrent edges latched, polled at each rise; eight halves force off
// - adc checked during the 1 ms window after rise; no hit in the window enables secondary monitor
// - secondary monitor: four halves with no adc hit force off
// - active motion at a wakeup restarts the 30 s timeout
// - 30 s without motion disables timer and enters off
// - light load pulse starts half the last measured crossing after the fall
// - tick timer advances an 8-bit counter and is also a motion wakeup
// - gate output held high in off state
// - single watchdog timeout in on state goes off, no retries
`timescale 1ns/10ps
module scrfc_ctrl #(
	parameter int unsigned PULSE_CYC = scrfc_pkg::PULSE_MAX_CYC,
	parameter int unsigned ZC_TO     = scrfc_pkg::ZC_TO_CYC,
	parameter int unsigned ADC_WIN   = scrfc_pkg::ADC_WIN_CYC,
	parameter int unsigned NO_MOTION_TIMEOUT    = scrfc_pkg::NO_MOTION_TIMEOUT_CYC,
	parameter int unsigned TICK_PER  = scrfc_pkg::TICK_CYC
) (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        resetn,
	// activation from the voltage acquisition logic
	input  wire logic                        on_start,
	input  wire logic [scrfc_pkg::CW-1:0]    mains_period,
	// pins
	input  wire logic                        current_zc_in,
	input  wire logic                        overcurrent_in,
	input  wire logic                        motion_in,
	output      logic                        scr_gate_out,
	// adc current sense
	input  wire logic                        adc_valid,
	input  wire logic [scrfc_pkg::AW-1:0]    current_sense_adc,
	input  wire logic [scrfc_pkg::AW-1:0]    min_thresh,
	// status
	output      logic                        on_state,
	output      logic                        gated_mode,
	output      logic                        voltage_edge_en,
	output      logic                        zc_fall_en,
	output      logic                        zc_rise_en,
	output      logic                        sec_mon_en,
	output      logic [scrfc_pkg::CW-1:0]    zc_stamp,
	output      logic [scrfc_pkg::CW-1:0]    zc_duration,
	output      logic [7:0]                  tick_count,
	output      scrfc_pkg::scrfc_fault_t     last_fault
);
	import scrfc_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [2:0]    zc_s;     // [0] first sync flop, [1] second, [2] prev
		logic [2:0]    oc_s;
		logic [1:0]    mot_s;
		scrfc_state_t  st;
		logic          pol;      // 0 waits fall, 1 waits rise
		logic [1:0]    nzc;      // completed crossings in pwm
		logic [CW-1:0] wd;
		logic [CW-1:0] stamp;
		logic [CW-1:0] dur;
		logic [CW-1:0] acc;
		logic [1:0]    nrel;
		logic [CW-1:0] reload;
		logic          oc_pend;
		logic [3:0]    oc_cnt;
		logic [CW-1:0] win;
		logic          sec_en;
		logic          uhit;
		logic [2:0]    uc_cnt;
		logic [31:0]   mot;
		logic [31:0]   tdiv;
		logic [7:0]    tick;
		scrfc_fault_t  fault;
	} scrfc_ctrl_st_t;

	scrfc_ctrl_st_t q, d;
	scrfc_tmr_if    tif ();

	logic zc_low;
	logic fall;
	logic rise;
	logic oc_rise;
	logic tick_evt;
	logic wake;
	logic adc_hit;
	scrfc_fault_t flt;

	// half of a measured crossing, used as the next pulse delay
	function automatic logic [CW-1:0] half(input logic [CW-1:0] v);
		half = v >> 1;
	endfunction

	// ****************************************************************
	// edges and events; only the second sync flop and later are read
	// ****************************************************************
	assign zc_low   = ~q.zc_s[1];
	assign fall     = q.zc_s[2] & ~q.zc_s[1];
	assign rise     = ~q.zc_s[2] & q.zc_s[1];
	assign oc_rise  = ~q.oc_s[2] & q.oc_s[1];
	assign tick_evt = (q.tdiv >= TICK_PER - 1);
	assign wake     = rise | fall | tick_evt;
	assign adc_hit  = adc_valid & (current_sense_adc > min_thresh);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		flt = SCRFC_F_NONE;
		tif.mode       = SCRFC_TM_OFF;
		tif.reload     = q.reload;
		tif.pwm_width  = CW'(PULSE_CYC);
		tif.clear      = 1'b0;
		tif.force_high = 1'b0;
		tif.gate       = zc_low;

		// pin synchronisers
		d.zc_s  = {q.zc_s[1:0], current_zc_in};
		d.oc_s  = {q.oc_s[1:0], overcurrent_in};
		d.mot_s = {q.mot_s[0], motion_in};

		// free tick timer; its event also serves as a wakeup for motion sampling
		d.tdiv = tick_evt ? '0 : q.tdiv + 32'd1;
		if (tick_evt)
			d.tick = q.tick + 8'h01;

		unique case (q.st)
			SCRFC_ST_OFF: begin
				// timer off keeps the gate high
				if (on_start) begin
					d.st     = SCRFC_ST_PWM;
					d.reload = mains_period;
					d.pol    = 1'b0;            // fall edge first
					d.nzc    = '0;
					d.wd     = '0;
					d.mot    = '0;
				end
			end
			SCRFC_ST_PWM, SCRFC_ST_GATED: begin
				// watchdog restarts at every rise
				d.wd = rise ? '0 : q.wd + CW'(1);
				if (q.st == SCRFC_ST_PWM) begin
					tif.mode = SCRFC_TM_PWM;
					if (!q.pol && fall) begin
						d.stamp = q.wd;
						d.pol   = 1'b1;
					end else if (q.pol && rise) begin
						d.stamp = q.wd;
						d.dur   = q.wd - q.stamp;
						d.pol   = 1'b0;
						d.nzc   = q.nzc + 2'h1;
						if (d.nzc == ZC_TO_GATED) begin
							d.st       = SCRFC_ST_GATED;
							d.reload   = half(d.dur);
							tif.mode   = SCRFC_TM_GATED;
							tif.clear  = 1'b1;
						end
					end
				end else begin
					// gated: counts only while zc low
					tif.mode = SCRFC_TM_GATED;
					if (fall) begin
						d.acc  = '0;
						d.nrel = '0;
					end
					if (tif.reload_evt) begin
						d.acc = q.acc + q.reload;
						if (q.nrel == 2'h0) begin
							d.reload = CW'(PULSE_CYC);
						end else begin
							tif.force_high = 1'b1;
						end
						if (q.nrel != 2'h3)
							d.nrel = q.nrel + 2'h1;
					end
					if (rise) begin
						d.dur      = q.acc + tif.count;
						d.reload   = half(d.dur);
						tif.clear  = 1'b1;
					end
				end

				// overcurrent polled once per half-cycle
				if (rise) begin
					d.oc_cnt  = q.oc_pend ? q.oc_cnt + 4'h1 : 4'h0;
					d.oc_pend = 1'b0;
				end
				if (oc_rise)
					d.oc_pend = 1'b1;            // set wins over the poll

				// primary adc window after each rise
				if (rise) begin
					d.win = CW'(ADC_WIN);
				end else if (q.win != '0) begin
					d.win = q.win - CW'(1);
					if (adc_hit) begin
						d.win    = '0;
						d.sec_en = 1'b0;
					end else if (q.win == CW'(1)) begin
						d.sec_en = 1'b1;
					end
				end

				// secondary monitor over each half-cycle
				if (rise) begin
					d.uhit = 1'b0;
					if (q.sec_en)
						d.uc_cnt = q.uhit ? 3'h0 : q.uc_cnt + 3'h1;
				end
				// a hit in the rise cycle belongs to the new half: set wins
				if (q.sec_en && !zc_low && adc_hit)
					d.uhit = 1'b1;

				// motion sampled at wakeups
				d.mot = q.mot + 32'd1;
				if (wake && q.mot_s[1])
					d.mot = '0;

				// fault checks, last wins in priority
				if (q.mot >= NO_MOTION_TIMEOUT - 1)
					flt = SCRFC_F_MOTION;
				if (q.uc_cnt >= UC_LIMIT)
					flt = SCRFC_F_UNDER;
				if (q.oc_cnt >= OC_LIMIT)
					flt = SCRFC_F_OVER;
				if (q.wd >= CW'(ZC_TO - 1))
					flt = SCRFC_F_ZC_TO;
			end
			default: d.st = SCRFC_ST_OFF;
		endcase

		// leaving for off: timer stopped and every counter cleared except the tick timer and tick counter
		if (flt != SCRFC_F_NONE) begin
			tif.mode   = SCRFC_TM_OFF;
			d.fault    = flt;
			d.st       = SCRFC_ST_OFF;
			d.pol      = 1'b0;
			d.nzc      = '0;
			d.wd       = '0;
			d.acc      = '0;
			d.nrel     = '0;
			d.oc_pend  = 1'b0;
			d.oc_cnt   = '0;
			d.win      = '0;
			d.sec_en   = 1'b0;
			d.uhit     = 1'b0;
			d.uc_cnt   = '0;
			d.mot      = '0;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q       <= '0;
			q.zc_s  <= 3'h7;                     // idle high, no false fall
			q.st    <= SCRFC_ST_OFF;
			q.fault <= SCRFC_F_NONE;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// gate pulse timer
	// ****************************************************************
	scrfc_timer u_timer (
		.clk    (clk),
		.resetn (resetn),
		.tif    (tif.tmr)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign scr_gate_out    = tif.out_n;         // registered in the timer
	assign on_state        = (q.st != SCRFC_ST_OFF);
	assign gated_mode      = (q.st == SCRFC_ST_GATED);
	assign voltage_edge_en = (q.st == SCRFC_ST_OFF);
	assign zc_fall_en      = (q.st == SCRFC_ST_PWM) & ~q.pol;
	assign zc_rise_en      = (q.st == SCRFC_ST_PWM) & q.pol;
	assign sec_mon_en      = q.sec_en;
	assign zc_stamp        = q.stamp;
	assign zc_duration     = q.dur;
	assign tick_count      = q.tick;
	assign last_fault      = q.fault;
endmodule

// File: sim/scrfc_load_model.sv
// load model driving the current zero-cross and overcurrent pins
`timescale 1ns/10ps
module scrfc_load_model #(
	parameter int unsigned HALF = 300,
	parameter int unsigned LOW  = 100
) (
	// clock
	input  wire logic clk,
	// controls from the bench
	input  wire logic en,
	input  wire logic oc_en,
	// pins towards the controller
	output      logic zc_n,
	output      logic oc
);
	int unsigned cnt = 0;
	// half-cycle phase counter, free running
	always_ff @(posedge clk) begin
		cnt <= (cnt + 1) % HALF;
	end
	// one crossing per half; with no current the line rests high
	assign zc_n = !(en && cnt < LOW);
	// overload pulse near the current peak, once per half
	assign oc = oc_en && en && cnt >= LOW + 10 && cnt < LOW + 20;
endmodule

// File: sim/scrfc_ctrl_checker.sv
// port assertions for the scr firing controller
`timescale 1ns/10ps
module scrfc_ctrl_checker #(
	parameter int unsigned PULSE_CYC = 40
) (
	// clock and reset
	input wire logic                    clk,
	input wire logic                    resetn,
	// activation and gate
	input wire logic                    on_start,
	input wire logic                    scr_gate_out,
	// status
	input wire logic                    on_state,
	input wire logic                    gated_mode,
	input wire logic                    voltage_edge_en,
	input wire logic                    zc_fall_en,
	input wire logic                    zc_rise_en,
	input wire logic                    sec_mon_en,
	input wire logic [7:0]              tick_count,
	input wire scrfc_pkg::scrfc_fault_t last_fault
);
	import scrfc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [23:0] low_q;
	logic [23:0] low_d;
	// length of the running low pulse; a stuck timer shows up here
	always_comb begin
		low_d = scr_gate_out ? 24'h0 : low_q + 24'h1;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_q <= 24'h0;
		end else begin
			low_q <= low_d;
		end
	end
	sequence s_take;
		on_start && !on_state;
	endsequence
	sequence s_fire;
		on_state ##1 !scr_gate_out;
	endsequence
	a_start_fires: assert property (s_take |=> s_fire)
		else $error("gate did not fire after start");
	a_vedge_off: assert property (voltage_edge_en == !on_state)
		else $error("voltage edge enable wrong");
	a_one_edge: assert property (!(zc_fall_en && zc_rise_en))
		else $error("both edge polarities enabled");
	a_gated_quiet: assert property (gated_mode |-> on_state
		&& !zc_fall_en && !zc_rise_en)
		else $error("edges enabled in gated mode");
	a_gated_clear: assert property ($rose(gated_mode)
		|-> ##[0:1] scr_gate_out)
		else $error("gate not cleared at gated switch");
	a_pulse_width: assert property (low_q <= PULSE_CYC)
		else $error("gate pulse too long");
	a_tick_step: assert property ($changed(tick_count)
		|-> tick_count == $past(tick_count) + 8'h1
		##1 $stable(tick_count)[*8])
		else $error("tick counter stepped wrongly");
	a_off_gate: assert property (!on_state && $past(!on_state)
		|-> scr_gate_out)
		else $error("gate low in off state");
	a_fault_off: assert property ($changed(last_fault)
		|-> ##[0:1] !on_state)
		else $error("fault without off state");
	a_off_clean: assert property ($fell(on_state)
		|-> ##[0:1] (!sec_mon_en && !gated_mode))
		else $error("state not cleared going off");
endmodule
bind scrfc_ctrl scrfc_ctrl_checker #(.PULSE_CYC(PULSE_CYC)) chk_u (
	.clk(clk), .resetn(resetn), .on_start(on_start),
	.scr_gate_out(scr_gate_out), .on_state(on_state),
	.gated_mode(gated_mode), .voltage_edge_en(voltage_edge_en),
	.zc_fall_en(zc_fall_en), .zc_rise_en(zc_rise_en),
	.sec_mon_en(sec_mon_en), .tick_count(tick_count),
	.last_fault(last_fault));

// File: sim/scrfc_ctrl_bench.sv
// self-checking bench for the scr firing controller
`timescale 1ns/10ps
module scrfc_ctrl_bench;
	import scrfc_pkg::*;
	// ****************************************************
	// signals and instances
	// ****************************************************
	logic         clk, resetn, on_start, motion_in, adc_valid;
	logic         en, oc_en, gate, on_st, gated, v_en, f_en, r_en, sec;
	logic [CW-1:0] period, stamp, dur;
	logic [AW-1:0] adc_val, thresh;
	logic [7:0]   tick;
	wire logic    zc, oc;
	scrfc_fault_t fault;
	int           n_errors, check_count, d, w, lowc, waited;
	// model defaults: 300-cycle half-cycle, pin low for the first 100
	scrfc_load_model load_u (
		.clk(clk), .en(en), .oc_en(oc_en), .zc_n(zc), .oc(oc));
	// short counts keep the run brief; expectations follow from them
	scrfc_ctrl #(.PULSE_CYC(40), .ZC_TO(4000), .ADC_WIN(20),
		.NO_MOTION_TIMEOUT(5000), .TICK_PER(100)) dut_u (
		.clk(clk), .resetn(resetn), .on_start(on_start),
		.mains_period(period), .current_zc_in(zc),
		.overcurrent_in(oc), .motion_in(motion_in),
		.scr_gate_out(gate), .adc_valid(adc_valid),
		.current_sense_adc(adc_val), .min_thresh(thresh),
		.on_state(on_st), .gated_mode(gated), .voltage_edge_en(v_en),
		.zc_fall_en(f_en), .zc_rise_en(r_en), .sec_mon_en(sec),
		.zc_stamp(stamp), .zc_duration(dur), .tick_count(tick),
		.last_fault(fault));
	// ****************************************************
	// tasks
	// ****************************************************
	task automatic chk(input string nm, input logic [CW-1:0] e, g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic rng(input string nm, input int lo, hi, g);
		check_count++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// a bound that runs out ends the run as a failure
	task automatic limit(input int i, lim);
		if (i >= lim) begin
			n_errors++;
			$display("[FAIL] wait expected done seen timeout");
			end_of_test();
		end
	endtask
	task automatic start();
		on_start = 1'b1;
		en = 1'b1;
		@(negedge clk);
		on_start = 1'b0;
		chk("on_state", 1, on_st);
		chk("volt_edge_en", 0, v_en);
		chk("fall_en", 1, f_en);
		@(negedge clk);
		chk("gate_first", 0, gate);
	endtask
	task automatic wait_off(input scrfc_fault_t f, input int lim);
		lowc = 0;
		for (waited = 0; waited < lim && on_st === 1'b1; waited++) begin
			@(negedge clk);
			lowc += (gate !== 1'b1);
		end
		limit(waited, lim);
		@(negedge clk);
		chk("fault", f, fault);
		chk("gate_off", 1, gate);
	endtask
	// delay from pin fall to pulse start, then pulse width
	task automatic pulse();
		int i;
		for (i = 0; i < 400 && zc !== 1'b1; i++) begin
			@(negedge clk);
		end
		limit(i, 400);
		for (i = 0; i < 400 && zc !== 1'b0; i++) begin
			@(negedge clk);
		end
		limit(i, 400);
		for (d = 0; d < 200 && gate === 1'b1; d++) begin
			@(negedge clk);
		end
		limit(d, 200);
		for (w = 0; w < 200 && gate === 1'b0; w++) begin
			@(negedge clk);
		end
		limit(w, 200);
	endtask
	// ****************************************************
	// clock and main sequence
	// ****************************************************
	initial begin
		clk = 1'b0;
		forever begin
			#12.5 clk = ~clk;
		end
	end
	initial begin
		int i;
		resetn = 1'b0;
		on_start = 1'b0;
		period = 24'h00012c;
		motion_in = 1'b1;
		adc_valid = 1'b1;
		adc_val = 12'hfff;
		thresh = ADC_MIN_DEF;
		en = 1'b0;
		oc_en = 1'b0;
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		chk("gate_reset", 1, gate);
		d = tick;
		repeat (100) @(negedge clk);
		chk("tick", CW'(d + 1), tick);
		start();
		// first pin fall flips the expected edge after the synchroniser
		for (i = 0; i < 400 && zc !== 1'b0; i++) begin
			@(negedge clk);
		end
		limit(i, 400);
		repeat (4) @(negedge clk);
		chk("rise_en", 1, r_en);
		chk("fall_en_flip", 0, f_en);
		for (i = 0; i < 2000 && gated !== 1'b1; i++) begin
			@(negedge clk);
		end
		limit(i, 2000);
		chk("dur_pwm", 24'h000064, dur);
		// rise to rise is one 300-cycle half, watchdog restarts at each rise
		chk("stamp", 24'h00012b, stamp);
		pulse();
		rng("pulse_delay", 48, 58, d);
		rng("pulse_width", 39, 41, w);
		repeat (20) @(negedge clk);
		chk("dur_gated", 24'h000064, dur);
		// load vanishes: no crossings, so no pulses, then timeout
		en = 1'b0;
		wait_off(SCRFC_F_ZC_TO, 4200);
		chk("no_pulse", 0, CW'(lowc));
		start();
		oc_en = 1'b1;
		wait_off(SCRFC_F_OVER, 4000);
		oc_en = 1'b0;
		// a sample equal to the threshold is not above it
		thresh = 12'hfff;
		start();
		for (i = 0; i < 1000 && sec !== 1'b1; i++) begin
			@(negedge clk);
		end
		limit(i, 1000);
		chk("sec_mon", 1, sec);
		wait_off(SCRFC_F_UNDER, 3000);
		thresh = ADC_MIN_DEF;
		// motion held, then dropped: timeout counts from the last wakeup
		start();
		repeat (3000) @(negedge clk);
		chk("motion_kept", 1, on_st);
		motion_in = 1'b0;
		wait_off(SCRFC_F_MOTION, 6000);
		rng("motion_wait", 4890, 5010, waited);
		end_of_test();
	end
endmodule
